// >>> spxp_pkg.sv
package spxp_pkg;

	// Register word addresses on the plain register port.
	localparam logic [7:0] SPXP_GCTL_ADDR = 8'h00;
	localparam logic [7:0] SPXP_PCTL_ADDR = 8'h04;

	// Bit positions in the global control word.
	localparam int unsigned SPXP_GCTL_RIE_BIT  = 0;
	localparam int unsigned SPXP_GCTL_RTIE_BIT = 1;
	localparam int unsigned SPXP_GCTL_XRST_BIT = 2;
	localparam int unsigned SPXP_GCTL_RRST_BIT = 3;
	localparam int unsigned SPXP_GCTL_TRANSMIT_FRAME_SYNC_MODE_BIT = 4;

	// Pin indices: transmit clock, transmit data, transmit frame sync.
	localparam int unsigned SPXP_NUM_PINS  = 3;
	localparam int unsigned SPXP_PIN_TCLK  = 0;
	localparam int unsigned SPXP_PIN_TDATA = 1;
	localparam int unsigned SPXP_PIN_TSYNC = 2;

	// Base bit of each pin's four-bit field group in the pin control word.
	localparam int unsigned SPXP_PIN_BASE [SPXP_NUM_PINS] = '{0, 4, 12};

	// Offsets inside one pin's field group.
	localparam int unsigned SPXP_FLD_FUNC = 0;
	localparam int unsigned SPXP_FLD_DIR  = 1;
	localparam int unsigned SPXP_FLD_DOUT = 2;
	localparam int unsigned SPXP_FLD_DIN  = 3;

	// Software waits this many cycles after system reset before releasing a side.
	localparam int unsigned SPXP_SOFT_RST_WAIT_CYC = 3;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} spxp_req_t;

	typedef struct packed {
		logic transmit_frame_sync_mode;
		logic rrst_n;
		logic xrst_n;
		logic rtie;
		logic rie;
	} spxp_gctl_t;

	typedef struct packed {
		logic din;
		logic dout;
		logic dir;
		logic func;
	} spxp_pin_t;

	typedef struct packed {
		spxp_gctl_t                       gctl;
		spxp_pin_t [SPXP_NUM_PINS-1:0]    pin;
		logic [31:0]                      rdata;
		logic                             tx_irq;
		logic                             rx_irq;
	} spxp_state_t;

	localparam spxp_state_t SPXP_STATE_RST = '0;

endpackage

// >>> spxp_ctrl.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

module spxp_ctrl (
	input  wire logic               CLK_I,
	input  wire logic               RST_N_I,
	input  wire spxp_pkg::spxp_req_t REG_REQ_I,
	output logic [31:0]             RD_DATA_O,
	input  wire logic               RX_EVENT_I,
	input  wire logic               RX_TIMER_EVENT_I,
	output logic                    RX_IRQ_O,
	output logic                    DMA_RX_EVENT_O,
	output logic                    TX_IRQ_O,
	output logic                    TX_RESET_N_O,
	output logic                    RX_RESET_N_O,
	output logic                    TX_FSYNC_MODE_O,
	input  wire logic [2:0]         SER_OUT_I,
	input  wire logic [2:0]         SER_OE_N_I,
	output logic [2:0]              SER_IN_O,
	input  wire logic [2:0]         PIN_I,
	output logic [2:0]              PIN_O,
	output logic [2:0]              PIN_OE_N_O
);

	spxp_pkg::spxp_state_t s;
	spxp_pkg::spxp_state_t next_s;

	function automatic logic [31:0] gctl_word(input spxp_pkg::spxp_gctl_t g);
		logic [31:0] w;
		w = '0;
		w[spxp_pkg::SPXP_GCTL_RIE_BIT]  = g.rie;
		w[spxp_pkg::SPXP_GCTL_RTIE_BIT] = g.rtie;
		w[spxp_pkg::SPXP_GCTL_XRST_BIT] = g.xrst_n;
		w[spxp_pkg::SPXP_GCTL_RRST_BIT] = g.rrst_n;
		w[spxp_pkg::SPXP_GCTL_TRANSMIT_FRAME_SYNC_MODE_BIT] = g.transmit_frame_sync_mode;
		return w;
	endfunction

	function automatic logic [31:0] pctl_word(input spxp_pkg::spxp_pin_t [2:0] p);
		logic [31:0] w;
		w = '0;
		for (int i = 0; i < 3; i++) begin
			w[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_FUNC] = p[i].func;
			w[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_DIR]  = p[i].dir;
			w[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_DOUT] = p[i].dout;
			w[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_DIN]  = p[i].din;
		end
		return w;
	endfunction

	always_comb begin
		next_s = s;
		next_s.rdata = '0;
		// Input bits follow the pin level every cycle, so writes never stick.
		for (int i = 0; i < 3; i++) begin
			next_s.pin[i].din = PIN_I[i];
		end
		// Enabled receive sources are merged into one flag for CPU and DMA.
		next_s.rx_irq = (s.gctl.rie & RX_EVENT_I) | (s.gctl.rtie & RX_TIMER_EVENT_I);
		if (REG_REQ_I.we) begin
			unique case (REG_REQ_I.addr)
				spxp_pkg::SPXP_GCTL_ADDR: begin
					next_s.gctl.rie    = REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RIE_BIT];
					next_s.gctl.rtie   = REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RTIE_BIT];
					next_s.gctl.xrst_n = REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_XRST_BIT];
					next_s.gctl.rrst_n = REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RRST_BIT];
					next_s.gctl.transmit_frame_sync_mode   = REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_TRANSMIT_FRAME_SYNC_MODE_BIT];
				end
				spxp_pkg::SPXP_PCTL_ADDR: begin
					for (int i = 0; i < 3; i++) begin
						next_s.pin[i].func =
							REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_FUNC];
						next_s.pin[i].dir =
							REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_DIR];
						next_s.pin[i].dout =
							REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[i] + spxp_pkg::SPXP_FLD_DOUT];
					end
				end
				default: begin
				end
			endcase
		end
		// A soft reset drives the side's reset output and leaves the pin bits alone; entering transmit reset also pulses tx_irq for one cycle.
		next_s.tx_irq = s.gctl.xrst_n & ~next_s.gctl.xrst_n;
		if (REG_REQ_I.re) begin
			unique case (REG_REQ_I.addr)
				spxp_pkg::SPXP_GCTL_ADDR: next_s.rdata = gctl_word(s.gctl);
				spxp_pkg::SPXP_PCTL_ADDR: next_s.rdata = pctl_word(s.pin);
				default: next_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s <= spxp_pkg::SPXP_STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign RD_DATA_O       = s.rdata;
	assign RX_IRQ_O        = s.rx_irq;
	assign DMA_RX_EVENT_O  = s.rx_irq;
	assign TX_IRQ_O        = s.tx_irq;
	assign TX_RESET_N_O    = s.gctl.xrst_n;
	assign RX_RESET_N_O    = s.gctl.rrst_n;
	assign TX_FSYNC_MODE_O = s.gctl.transmit_frame_sync_mode;

	// The enable is active low: a GPIO input leaves the pin undriven.
	for (genvar g = 0; g < 3; g++) begin : g_pin
		assign PIN_O[g]      = s.pin[g].func ? SER_OUT_I[g] : s.pin[g].dout;
		assign PIN_OE_N_O[g] = s.pin[g].func ? SER_OE_N_I[g] : ~s.pin[g].dir;
		assign SER_IN_O[g]   = s.pin[g].func & PIN_I[g];
	end

	default clocking dc @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	logic wr_gctl;
	logic wr_pctl;
	assign wr_gctl = REG_REQ_I.we && (REG_REQ_I.addr == spxp_pkg::SPXP_GCTL_ADDR);
	assign wr_pctl = REG_REQ_I.we && (REG_REQ_I.addr == spxp_pkg::SPXP_PCTL_ADDR);

	rx_irq_gate_a: assert property (
		(!(s.gctl.rie && RX_EVENT_I) && !(s.gctl.rtie && RX_TIMER_EVENT_I)) |=> !RX_IRQ_O
	) else $error("receive flag raised without an enabled source");

	rx_irq_or_a: assert property (
		((s.gctl.rie && RX_EVENT_I) || (s.gctl.rtie && RX_TIMER_EVENT_I))
		|=> (RX_IRQ_O && DMA_RX_EVENT_O)
	) else $error("enabled receive source did not raise flag and DMA event");

	tx_hold_rst_a: assert property (
		(wr_gctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_XRST_BIT])
		|=> !TX_RESET_N_O ##1 (!TX_RESET_N_O || $past(wr_gctl))
	) else $error("transmit side left reset without a write");

	rx_hold_rst_a: assert property (
		(wr_gctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RRST_BIT]) |=> !RX_RESET_N_O
	) else $error("receive side not held in reset");

	rst_keeps_regs_a: assert property (
		(wr_gctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_XRST_BIT])
		|=> ($stable({s.pin[0][2:0], s.pin[1][2:0], s.pin[2][2:0]}) && $stable(s.gctl.transmit_frame_sync_mode)
			|| $past(s.gctl.transmit_frame_sync_mode) != $past(REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_TRANSMIT_FRAME_SYNC_MODE_BIT]))
	) else $error("soft reset disturbed control bits");

	tx_irq_link_a: assert property (
		$fell(TX_RESET_N_O) |-> TX_IRQ_O ##1 !TX_IRQ_O
	) else $error("entering transmit reset gave no single interrupt pulse");

	tx_irq_cause_a: assert property (
		TX_IRQ_O |-> $fell(TX_RESET_N_O)
	) else $error("transmit interrupt without entering reset");

	rsvd_zero_a: assert property (
		(REG_REQ_I.re && REG_REQ_I.addr == spxp_pkg::SPXP_PCTL_ADDR)
		|=> (RD_DATA_O[31:16] == 16'h0000) && (RD_DATA_O[11:8] == 4'h0)
	) else $error("reserved pin control bits read nonzero");

	for (genvar g = 0; g < 3; g++) begin : g_chk
		serial_own_a: assert property (
			s.pin[g].func |-> (PIN_O[g] == SER_OUT_I[g]) && (PIN_OE_N_O[g] == SER_OE_N_I[g])
		) else $error("serial mode pin not owned by serial logic");
		gpio_out_a: assert property (
			(wr_pctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[g]]
				&& REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[g] + spxp_pkg::SPXP_FLD_DIR])
			|=> !PIN_OE_N_O[g] && (PIN_O[g] ==
				$past(REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[g] + spxp_pkg::SPXP_FLD_DOUT]))
		) else $error("GPIO output pin not driven from its output bit");
		gpio_in_a: assert property (
			(!s.pin[g].func && !s.pin[g].dir) |-> PIN_OE_N_O[g] ##1 (s.pin[g].din == $past(PIN_I[g]))
		) else $error("GPIO input pin driven or level not captured");
	end

	// Read strobes decoded once so the read-back checks stay short.
	logic rd_gctl;
	logic rd_pctl;
	logic rd_other;
	assign rd_gctl  = REG_REQ_I.re && (REG_REQ_I.addr == spxp_pkg::SPXP_GCTL_ADDR);
	assign rd_pctl  = REG_REQ_I.re && (REG_REQ_I.addr == spxp_pkg::SPXP_PCTL_ADDR);
	assign rd_other = REG_REQ_I.re && !rd_gctl && !rd_pctl;

	// Both receive outputs must always agree, since they share one source.
	rx_dma_same_a: assert property (
		RX_IRQ_O == DMA_RX_EVENT_O
	) else $error("receive flag and DMA event differ");

	rx_event_gate_a: assert property (
		(s.gctl.rie && RX_EVENT_I) |=> RX_IRQ_O
	) else $error("enabled receive event gave no flag");

	rx_timer_gate_a: assert property (
		(s.gctl.rtie && RX_TIMER_EVENT_I) |=> RX_IRQ_O
	) else $error("enabled receive timer event gave no flag");

	rx_en_zero_a: assert property (
		(!s.gctl.rie && !s.gctl.rtie) |=> !RX_IRQ_O
	) else $error("receive flag raised with both sources disabled");

	rie_write_a: assert property (
		wr_gctl |=> s.gctl.rie == $past(REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RIE_BIT])
	) else $error("receive enable bit did not take the written value");

	rie_hold_a: assert property (
		!wr_gctl |=> $stable(s.gctl.rie)
	) else $error("receive enable bit changed without a write");

	rtie_write_a: assert property (
		wr_gctl |=> s.gctl.rtie == $past(REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RTIE_BIT])
	) else $error("receive timer enable bit did not take the written value");

	tx_release_a: assert property (
		(wr_gctl && REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_XRST_BIT]) |=> TX_RESET_N_O
	) else $error("transmit side not released by a write of one");

	tx_rst_hold_a: assert property (
		!wr_gctl |=> $stable(TX_RESET_N_O)
	) else $error("transmit reset output changed without a write");

	rx_release_a: assert property (
		(wr_gctl && REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RRST_BIT]) |=> RX_RESET_N_O
	) else $error("receive side not released by a write of one");

	rx_rst_hold_a: assert property (
		!wr_gctl |=> $stable(RX_RESET_N_O)
	) else $error("receive reset output changed without a write");

	// The frame-sync mode follows its own bit whatever the reset bits do.
	fsm_write_a: assert property (
		wr_gctl |=> TX_FSYNC_MODE_O == $past(REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_TRANSMIT_FRAME_SYNC_MODE_BIT])
	) else $error("frame-sync mode did not take the written value");

	fsm_hold_a: assert property (
		!wr_gctl |=> $stable(TX_FSYNC_MODE_O)
	) else $error("frame-sync mode changed without a write");

	rx_rst_keeps_a: assert property (
		(wr_gctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RRST_BIT])
		|=> $stable({s.pin[0][2:0], s.pin[1][2:0], s.pin[2][2:0]})
	) else $error("receive soft reset disturbed pin control bits");

	tx_irq_entry_a: assert property (
		(wr_gctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_XRST_BIT] && s.gctl.xrst_n)
		|=> TX_IRQ_O
	) else $error("entering transmit reset raised no interrupt");

	tx_irq_single_a: assert property (
		TX_IRQ_O |=> !TX_IRQ_O
	) else $error("transmit interrupt longer than one cycle");

	tx_irq_quiet_a: assert property (
		!wr_gctl |=> !TX_IRQ_O
	) else $error("transmit interrupt without a control write");

	// Read data stand for one cycle only and are zero otherwise.
	rd_idle_zero_a: assert property (
		!REG_REQ_I.re |=> RD_DATA_O == 32'h00000000
	) else $error("read data nonzero without a read");

	rd_gctl_a: assert property (
		rd_gctl |=> RD_DATA_O == {27'h0000000, $past(s.gctl)}
	) else $error("global control read back wrong");

	rd_unmapped_a: assert property (
		rd_other |=> RD_DATA_O == 32'h00000000
	) else $error("unmapped read returned nonzero");

	for (genvar g = 0; g < 3; g++) begin : g_fld_chk
		func_write_a: assert property (
			wr_pctl |=> s.pin[g].func ==
				$past(REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[g] + spxp_pkg::SPXP_FLD_FUNC])
		) else $error("function select did not take the written value");

		dir_write_a: assert property (
			wr_pctl |=> s.pin[g].dir ==
				$past(REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[g] + spxp_pkg::SPXP_FLD_DIR])
		) else $error("direction bit did not take the written value");

		dout_write_a: assert property (
			wr_pctl |=> s.pin[g].dout ==
				$past(REG_REQ_I.wdata[spxp_pkg::SPXP_PIN_BASE[g] + spxp_pkg::SPXP_FLD_DOUT])
		) else $error("output data bit did not take the written value");

		ctl_hold_a: assert property (
			!wr_pctl |=> $stable(s.pin[g][2:0])
		) else $error("pin control bits changed without a write");

		// A write to the input bit must never stick; it always shows the pin.
		din_track_a: assert property (
			1'b1 |=> s.pin[g].din == $past(PIN_I[g])
		) else $error("input data bit does not follow the pin");

		din_read_a: assert property (
			rd_pctl |=> RD_DATA_O[spxp_pkg::SPXP_PIN_BASE[g] + spxp_pkg::SPXP_FLD_DIN]
				== $past(s.pin[g].din)
		) else $error("input data bit read back wrong");

		ctl_read_a: assert property (
			rd_pctl |=> RD_DATA_O[spxp_pkg::SPXP_PIN_BASE[g] +: 3] == $past(s.pin[g][2:0])
		) else $error("pin control bits read back wrong");

		gpio_dir_a: assert property (
			!s.pin[g].func |-> PIN_OE_N_O[g] == !s.pin[g].dir
		) else $error("GPIO pin enable does not follow its direction bit");

		gpio_lvl_a: assert property (
			(!s.pin[g].func && s.pin[g].dir) |-> PIN_O[g] == s.pin[g].dout
		) else $error("GPIO output level does not follow its output bit");

		ser_in_gate_a: assert property (
			!s.pin[g].func |-> !SER_IN_O[g]
		) else $error("serial logic sees a GPIO pin");

		ser_in_pass_a: assert property (
			s.pin[g].func |-> SER_IN_O[g] == PIN_I[g]
		) else $error("serial logic does not see its pin");
	end

	tx_reset_cycle_c: cover property (
		wr_gctl && !REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_XRST_BIT] && TX_RESET_N_O ##1 TX_IRQ_O
	);
	rx_irq_c: cover property (RX_IRQ_O && s.gctl.rie);
	gpio_drive_c: cover property (!s.pin[1].func && !PIN_OE_N_O[1] && PIN_O[1]);
	serial_mode_c: cover property (s.pin[0].func && s.pin[2].func && TX_RESET_N_O);
	rx_release_c: cover property (
		wr_gctl && REG_REQ_I.wdata[spxp_pkg::SPXP_GCTL_RRST_BIT] && !RX_RESET_N_O ##1 RX_RESET_N_O
	);

endmodule

// >>> spxp_peer.sv
`timescale 1ns/10ps
module spxp_peer (
	input  wire logic [2:0] pin_o_i,
	input  wire logic [2:0] pin_oe_n_i,
	input  wire logic [2:0] peer_val_i,
	output logic      [2:0] pin_lvl_o
);
	// The peer drives only pins that the device leaves undriven, so they never fight.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_lvl_o[i] = pin_oe_n_i[i] ? peer_val_i[i] : pin_o_i[i];
		end
	end
endmodule

// >>> spxp_ctrl_tb.sv
`timescale 1ns/10ps
module spxp_ctrl_tb;
	logic                clk;
	logic                rst_n;
	logic                rx_ev;
	logic                rx_tev;
	spxp_pkg::spxp_req_t req;
	logic [31:0]         rd;
	logic                rx_irq;
	logic                dma_ev;
	logic                tx_irq;
	logic                tx_rst_n;
	logic                rx_rst_n;
	logic                fsm;
	logic [2:0]          ser_out;
	logic [2:0]          ser_oe_n;
	logic [2:0]          ser_in;
	logic [2:0]          pin_lvl;
	logic [2:0]          pin_o;
	logic [2:0]          pin_oe_n;
	logic [2:0]          peer_val;
	logic [31:0]         pctl;
	logic [31:0]         v;
	int                  fail_count;
	int                  check_count;
	int                  seed;
	int                  cyc;

	spxp_ctrl spxp_ctrl_inst (.CLK_I(clk), .RST_N_I(rst_n), .REG_REQ_I(req), .RD_DATA_O(rd),
		.RX_EVENT_I(rx_ev), .RX_TIMER_EVENT_I(rx_tev), .RX_IRQ_O(rx_irq),
		.DMA_RX_EVENT_O(dma_ev), .TX_IRQ_O(tx_irq), .TX_RESET_N_O(tx_rst_n),
		.RX_RESET_N_O(rx_rst_n), .TX_FSYNC_MODE_O(fsm), .SER_OUT_I(ser_out),
		.SER_OE_N_I(ser_oe_n), .SER_IN_O(ser_in), .PIN_I(pin_lvl), .PIN_O(pin_o),
		.PIN_OE_N_O(pin_oe_n));
	spxp_peer spxp_peer_inst (.pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n), .peer_val_i(peer_val),
		.pin_lvl_o(pin_lvl));

	always #2 clk = ~clk;

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fail_count++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A write or a read of one cycle; read data are caught in the cycle after the strobe.
	task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		req <= '{a, d, w, ~w};
		@(posedge clk);
		req <= '0;
		#1 v = rd;
	endtask

	function automatic logic [8:0] e_pin(input logic [31:0] p);
		logic [2:0] oe;
		logic [2:0] o;
		logic [2:0] si;
		int         b;
		for (int i = 0; i < 3; i++) begin
			b = spxp_pkg::SPXP_PIN_BASE[i];
			oe[i] = p[b] ? ser_oe_n[i] : ~p[b+1];
			o[i] = p[b] ? ser_out[i] : p[b+2];
			si[i] = p[b] & (oe[i] ? peer_val[i] : o[i]);
		end
		return {oe, o, si};
	endfunction

	function automatic logic [31:0] e_rd(input logic [31:0] p);
		logic [31:0] r;
		logic [8:0]  e;
		int          b;
		r = '0;
		e = e_pin(p);
		for (int i = 0; i < 3; i++) begin
			b = spxp_pkg::SPXP_PIN_BASE[i];
			r[b+:3] = p[b+:3];
			r[b+3] = e[6+i] ? peer_val[i] : e[3+i];
		end
		return r;
	endfunction

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		req = '0;
		rx_ev = 1'b0;
		rx_tev = 1'b0;
		ser_out = 3'h0;
		ser_oe_n = 3'h7;
		peer_val = 3'h0;
		seed = 120;
		cyc = 0;
		fail_count = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk(32'({tx_rst_n, rx_rst_n, tx_irq, rx_irq, pin_oe_n}), 32'h07);
		bus(spxp_pkg::SPXP_PCTL_ADDR, 32'h0, 1'b0);
		chk(v, 32'h0);
		bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h0, 1'b0);
		chk(v, 32'h0);
		repeat (3) @(posedge clk);
		$display("reset test done");
		for (int k = 0; k < 16; k++) begin
			bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h0C | 32'(k[1:0]), 1'b1);
			@(posedge clk);
			rx_ev <= k[2];
			rx_tev <= k[3];
			@(posedge clk);
			#1 chk(32'({rx_irq, dma_ev}), {30'h0, {2{(k[0] & k[2]) | (k[1] & k[3])}}});
		end
		rx_ev <= 1'b0;
		$display("receive interrupt test done");
		bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h1D, 1'b1);
		chk(32'({tx_irq, tx_rst_n, rx_rst_n, fsm}), 32'h7);
		bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h19, 1'b1);
		chk(32'({tx_irq, tx_rst_n}), 32'h2);
		@(posedge clk);
		#1 chk(32'(tx_irq), 32'h0);
		bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h11, 1'b1);
		chk(32'({tx_irq, rx_rst_n}), 32'h0);
		bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h0, 1'b0);
		chk(v, 32'h11);
		$display("soft reset test done");
		repeat (40) begin
			@(posedge clk);
			v = $random(seed);
			ser_out <= v[2:0];
			ser_oe_n <= v[5:3];
			peer_val <= v[8:6];
			pctl = $random(seed);
			bus(spxp_pkg::SPXP_PCTL_ADDR, pctl, 1'b1);
			chk(32'({pin_oe_n, pin_o, ser_in}), 32'(e_pin(pctl)));
			bus(spxp_pkg::SPXP_PCTL_ADDR, 32'h0, 1'b0);
			chk(v, e_rd(pctl));
		end
		$display("pin test done");
		bus(8'h08, 32'hFFFFFFFF, 1'b1);
		bus(8'h08, 32'h0, 1'b0);
		chk(v, 32'h0);
		bus(spxp_pkg::SPXP_GCTL_ADDR, 32'h0, 1'b0);
		chk(v, 32'h11);
		$display("unmapped test done");
		results();
	end
endmodule
